// ---- include/diag_pkg.sv ----
package diag_pkg;
  // Command codes
  localparam logic [7:0] CMD_READ_STAT = 8'h00;
  localparam logic [7:0] CMD_READ_ALARM = 8'h02;
  localparam logic [7:0] CMD_HIST = 8'h33;
  localparam logic [7:0] CMD_SNAP = 8'h35;
  localparam logic [7:0] CMD_ALARM_CTL = 8'h82;
  localparam logic [7:0] CMD_TEST = 8'h8b;
  localparam logic [7:0] CMD_OUT_SET = 8'h92;
  // Data numbers
  localparam logic [7:0] DN_TEST_MODE = 8'h12;
  localparam logic [7:0] DN_ZERO = 8'h00;
  localparam logic [7:0] DN_OUT_PAT = 8'ha0;
  localparam logic [7:0] DN_HIST_CLR = 8'h20;
  localparam logic [7:0] DN_POS_PULSE = 8'h90;
  localparam logic [7:0] DN_POS_CMD = 8'h91;
  localparam logic [7:0] DN_VERSION = 8'h70;
  localparam logic [3:0] DN_HIST_CODE_HI = 4'h1;
  localparam logic [3:0] DN_HIST_TIME_HI = 4'h2;
  localparam logic [7:0] DN_SNAP_A_LO = 8'h80;
  localparam logic [7:0] DN_SNAP_A_HI = 8'h8e;
  localparam logic [7:0] DN_SNAP_B_LO = 8'ha0;
  localparam logic [7:0] DN_SNAP_B_HI = 8'ha9;
  localparam logic [4:0] SNAP_B_BASE = 5'h0f;
  // Values
  localparam logic [31:0] KEYWORD = 32'h0000_1ea5;
  localparam logic [31:0] TEST_SEL_DO = 32'h0000_0004;
  localparam logic [31:0] TEST_CANCEL = 32'h0000_0000;
  localparam logic [15:0] NO_ALARM = 16'h00ff;
  localparam logic [2:0] TMODE_NORMAL = 3'h0;
  localparam logic [2:0] TMODE_DO = 3'h4;
  localparam int DO_PINS = 9;
  localparam int HIST_DEPTH = 16;
  localparam int SNAP_ITEMS = 25;
  // Timing
  localparam int CLK_MHZ = 200;
  localparam int IDLE_LIMIT_MS = 500;
  localparam int IDLE_CYCLES = IDLE_LIMIT_MS * CLK_MHZ * 1000;

  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] dnum;
    logic [31:0] data;
  } cmd_t;

  typedef struct packed {
    logic [15:0] code;
    logic [15:0] hours;
  } hist_entry_t;
endpackage

// ---- logic/hist_mem.sv ----
`timescale 1ns/10ps
module hist_mem
  import diag_pkg::*;
#(
  parameter int DEPTH = HIST_DEPTH
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic push_i,
  input wire hist_entry_t push_entry_i,
  input wire logic clear_i,
  input wire logic [3:0] rd_idx_i,
  output hist_entry_t rd_entry_o
);
  hist_entry_t mem_r [DEPTH];
  hist_entry_t rd_r;
  // Shift store: entry 0 newest, last entry oldest; clear wins over push
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_ent
      if (g == 0) begin : g_head
        always_ff @(posedge sys_clk_i) begin
          if (srst_i || clear_i) begin
            mem_r[g] <= '{code: NO_ALARM, hours: 16'h0000};
          end else if (push_i) begin
            mem_r[g] <= push_entry_i;
          end
        end
      end else begin : g_tail
        always_ff @(posedge sys_clk_i) begin
          if (srst_i || clear_i) begin
            mem_r[g] <= '{code: NO_ALARM, hours: 16'h0000};
          end else if (push_i) begin
            mem_r[g] <= mem_r[g-1];
          end
        end
      end
    end
  endgenerate
  // Registered read port
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      rd_r <= '{code: NO_ALARM, hours: 16'h0000};
    end else begin
      rd_r <= mem_r[rd_idx_i];
    end
  end
  assign rd_entry_o = rd_r;
endmodule

// ---- logic/servo_diag_command_handler.sv ----
`timescale 1ns/10ps
// Functional notes
// [R1] Forced mode drives outputs from pattern
// [R2] Master disables normal outputs beforehand
// [R3] Test command value 0004 enters forced mode
// [R4] Pattern bits 0..8 drive pins
// [R5] Test command value 0000 cancels test mode
// [R6] Sixteen entry history, codes at 10..1F
// [R7] Codes four hex digits, 00FF none
// [R8] Entry hours read at 20..2F
// [R9] Keyword on 82/20 erases history
// [R10] Command 02/00 returns active alarm
// [R11] Command 35 returns captured status items
// [R12] Keyword on 82/00 resets active alarm
// [R13] Command 02/90 returns pulse position
// [R14] Command 02/91 returns command position
// [R15] Command 02/70 returns firmware version
// [R16] Link idle in test mode stops motor
// [R17] Command 00/12 reports test mode
// [R18] Wrong keyword leaves alarms unchanged
module servo_diag_command_handler
  import diag_pkg::*;
#(
  parameter int IDLE_COUNT = IDLE_CYCLES,
  parameter logic [31:0] FW_VERSION = 32'h0000_0001 // Arbitrary value
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic cmd_valid_i,
  input wire cmd_t cmd_i,
  input wire logic link_activity_i,
  input wire logic alarm_event_i,
  input wire logic [15:0] alarm_code_i,
  input wire logic [15:0] op_hours_i,
  input wire logic [SNAP_ITEMS*32-1:0] status_live_i,
  input wire logic [31:0] pos_pulse_i,
  input wire logic [31:0] pos_cmd_i,
  input wire logic [DO_PINS-1:0] normal_do_i,
  input wire logic alarm_clear_input_i,
  output logic reply_valid_o,
  output logic [31:0] reply_data_o,
  output logic [DO_PINS-1:0] do_pins_o,
  output logic [15:0] active_alarm_o,
  output logic [2:0] test_mode_o,
  output logic motor_stop_o,
  output logic alarm_reset_o
);
  // ****************************************
  // State
  // ****************************************
  typedef enum logic [1:0] {ST_IDLE, ST_HIST_WAIT, ST_HIST_REPLY} phase_t;
  typedef struct packed {
    phase_t phase;
    logic hist_time;
    logic [3:0] hidx;
    logic [2:0] tmode;
    logic [DO_PINS-1:0] pattern;
    logic [15:0] alarm;
    logic [31:0] idle_cnt;
    logic stop;
    logic rvalid;
    logic [31:0] rdata;
    logic areset;
    logic [SNAP_ITEMS*32-1:0] snap;
  } state_t;
  state_t st_r, st_nxt;
  logic hist_clear;
  logic [3:0] hist_idx;
  hist_entry_t hist_rd;
  logic [4:0] snap_idx;
  logic is_kw;

  hist_mem #(.DEPTH(HIST_DEPTH)) hist_mem_inst (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .push_i(alarm_event_i),
    .push_entry_i({alarm_code_i, op_hours_i}),
    .clear_i(hist_clear),
    .rd_idx_i(hist_idx),
    .rd_entry_o(hist_rd)
  );

  // ****************************************
  // Decode helpers
  // ****************************************
  assign is_kw = (cmd_i.data == KEYWORD);
  // Index held through the read wait, the command word is gone by then
  assign hist_idx = (st_r.phase == ST_IDLE) ? cmd_i.dnum[3:0] : st_r.hidx; // [R6]
  assign hist_clear = cmd_valid_i && cmd_i.cmd == CMD_ALARM_CTL && st_r.phase == ST_IDLE
    && cmd_i.dnum == DN_HIST_CLR && is_kw; // [R9] [R18]
  always_comb begin
    snap_idx = 5'h00;
    if (cmd_i.dnum[7:4] == 4'h8) begin
      snap_idx = {1'b0, cmd_i.dnum[3:0]};
    end else begin
      snap_idx = 5'(SNAP_B_BASE + {1'b0, cmd_i.dnum[3:0]});
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.rvalid = 1'b0;
    st_nxt.areset = 1'b0;
    // Idle watchdog while in test mode
    if (link_activity_i || cmd_valid_i || st_r.tmode == TMODE_NORMAL) begin
      st_nxt.idle_cnt = 32'h0000_0000;
    end else if (st_r.idle_cnt < 32'(IDLE_COUNT)) begin
      st_nxt.idle_cnt = st_r.idle_cnt + 32'h0000_0001;
    end else begin
      st_nxt.stop = 1'b1; // [R16]
    end
    if (st_r.tmode == TMODE_NORMAL) begin
      st_nxt.stop = 1'b0;
    end
    // Alarm capture and status snapshot
    if (alarm_event_i) begin
      st_nxt.alarm = alarm_code_i;
      st_nxt.snap = status_live_i; // [R11]
    end
    case (st_r.phase)
      ST_IDLE: begin
        if (cmd_valid_i) begin
          case (cmd_i.cmd)
            CMD_TEST: begin
              if (cmd_i.dnum == DN_ZERO && cmd_i.data == TEST_SEL_DO) begin
                st_nxt.tmode = TMODE_DO; // [R3]
              end else if (cmd_i.dnum == DN_ZERO && cmd_i.data == TEST_CANCEL) begin
                st_nxt.tmode = TMODE_NORMAL; // [R5]
                st_nxt.pattern = '0;
              end
            end
            CMD_OUT_SET: begin
              if (cmd_i.dnum == DN_OUT_PAT && st_r.tmode == TMODE_DO) begin
                st_nxt.pattern = cmd_i.data[DO_PINS-1:0]; // [R4]
              end
            end
            CMD_READ_STAT: begin
              if (cmd_i.dnum == DN_TEST_MODE) begin
                st_nxt.rvalid = 1'b1;
                st_nxt.rdata = {29'h0, st_r.tmode}; // [R17]
              end
            end
            CMD_READ_ALARM: begin
              st_nxt.rvalid = 1'b1;
              case (cmd_i.dnum)
                DN_ZERO: st_nxt.rdata = {16'h0000, st_r.alarm}; // [R10] [R7]
                DN_POS_PULSE: st_nxt.rdata = pos_pulse_i; // [R13]
                DN_POS_CMD: st_nxt.rdata = pos_cmd_i; // [R14]
                DN_VERSION: st_nxt.rdata = FW_VERSION; // [R15]
                default: st_nxt.rvalid = 1'b0;
              endcase
            end
            CMD_HIST: begin
              if (cmd_i.dnum[7:4] == DN_HIST_CODE_HI || cmd_i.dnum[7:4] == DN_HIST_TIME_HI) begin
                st_nxt.hist_time = (cmd_i.dnum[7:4] == DN_HIST_TIME_HI); // [R8]
                st_nxt.hidx = cmd_i.dnum[3:0]; // [R6]
                st_nxt.phase = ST_HIST_WAIT;
              end
            end
            CMD_SNAP: begin
              if ((cmd_i.dnum >= DN_SNAP_A_LO && cmd_i.dnum <= DN_SNAP_A_HI)
                  || (cmd_i.dnum >= DN_SNAP_B_LO && cmd_i.dnum <= DN_SNAP_B_HI)) begin
                st_nxt.rvalid = 1'b1;
                st_nxt.rdata = st_r.snap[snap_idx*32 +: 32]; // [R11]
              end
            end
            CMD_ALARM_CTL: begin
              if (cmd_i.dnum == DN_ZERO && is_kw && !alarm_event_i) begin
                st_nxt.alarm = NO_ALARM; // [R12] [R18]
                st_nxt.areset = 1'b1;
              end
            end
            default: st_nxt.rvalid = 1'b0;
          endcase
        end
      end
      ST_HIST_WAIT: st_nxt.phase = ST_HIST_REPLY;
      ST_HIST_REPLY: begin
        st_nxt.rvalid = 1'b1;
        st_nxt.rdata = {16'h0000, st_r.hist_time ? hist_rd.hours : hist_rd.code}; // [R7] [R8]
        st_nxt.phase = ST_IDLE;
      end
      default: st_nxt.phase = ST_IDLE;
    endcase
    // Hardware reset input clears the active alarm as the reset command does, without its alarm_reset_o pulse
    if (alarm_clear_input_i && !alarm_event_i) begin
      st_nxt.alarm = NO_ALARM; // [R12]
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      st_r <= '{phase: ST_IDLE, hist_time: 1'b0, tmode: TMODE_NORMAL, pattern: '0,
                alarm: NO_ALARM, idle_cnt: 32'h0000_0000, stop: 1'b0, rvalid: 1'b0,
                rdata: 32'h0000_0000, areset: 1'b0, hidx: 4'h0, snap: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs; forced pattern overrides normal drive
  assign do_pins_o = (st_r.tmode == TMODE_DO) ? st_r.pattern : normal_do_i; // [R1] [R2]
  assign reply_valid_o = st_r.rvalid;
  assign reply_data_o = st_r.rdata;
  assign active_alarm_o = st_r.alarm;
  assign test_mode_o = st_r.tmode;
  assign motor_stop_o = st_r.stop;
  assign alarm_reset_o = st_r.areset;

  // ****************************************
  // Checks
  // ****************************************
  sequence s_enter_do;
    cmd_valid_i && st_r.phase == ST_IDLE && cmd_i.cmd == CMD_TEST
      && cmd_i.dnum == DN_ZERO && cmd_i.data == TEST_SEL_DO;
  endsequence
  property p_enter_do;
    @(posedge sys_clk_i) disable iff (srst_i) s_enter_do |=> test_mode_o == TMODE_DO;
  endproperty
  a_enter_do: assert property (p_enter_do) else $error("forced mode not entered"); // [R3]
  property p_cancel;
    @(posedge sys_clk_i) disable iff (srst_i)
      (cmd_valid_i && st_r.phase == ST_IDLE && cmd_i.cmd == CMD_TEST && cmd_i.dnum == DN_ZERO
       && cmd_i.data == TEST_CANCEL) |=> test_mode_o == TMODE_NORMAL;
  endproperty
  a_cancel: assert property (p_cancel) else $error("test mode not cancelled"); // [R5]
  property p_forced;
    @(posedge sys_clk_i) disable iff (srst_i)
      (cmd_valid_i && st_r.phase == ST_IDLE && cmd_i.cmd == CMD_OUT_SET
       && cmd_i.dnum == DN_OUT_PAT && test_mode_o == TMODE_DO)
      |=> do_pins_o == $past(cmd_i.data[DO_PINS-1:0]);
  endproperty
  a_forced: assert property (p_forced) else $error("pins not forced"); // [R1] [R4]
  property p_hist_read;
    @(posedge sys_clk_i) disable iff (srst_i)
      (cmd_valid_i && st_r.phase == ST_IDLE && cmd_i.cmd == CMD_HIST
       && cmd_i.dnum[7:4] == DN_HIST_CODE_HI) |-> ##3 reply_valid_o;
  endproperty
  a_hist_read: assert property (p_hist_read) else $error("history reply late"); // [R6]
  property p_cur_alarm;
    @(posedge sys_clk_i) disable iff (srst_i)
      (cmd_valid_i && st_r.phase == ST_IDLE && cmd_i.cmd == CMD_READ_ALARM
       && cmd_i.dnum == DN_ZERO) |=> reply_valid_o && reply_data_o[15:0] == $past(active_alarm_o);
  endproperty
  a_cur_alarm: assert property (p_cur_alarm) else $error("wrong current alarm"); // [R10]
  property p_reset_kw;
    @(posedge sys_clk_i) disable iff (srst_i)
      (cmd_valid_i && st_r.phase == ST_IDLE && cmd_i.cmd == CMD_ALARM_CTL && cmd_i.dnum == DN_ZERO
       && is_kw && !alarm_event_i) |=> active_alarm_o == NO_ALARM && alarm_reset_o;
  endproperty
  a_reset_kw: assert property (p_reset_kw) else $error("alarm not reset"); // [R12]
  property p_bad_kw;
    @(posedge sys_clk_i) disable iff (srst_i)
      (cmd_valid_i && cmd_i.cmd == CMD_ALARM_CTL && !is_kw && !alarm_event_i
       && !alarm_clear_input_i) |=> $stable(active_alarm_o) && !alarm_reset_o;
  endproperty
  a_bad_kw: assert property (p_bad_kw) else $error("bad keyword acted"); // [R18]
  property p_version;
    @(posedge sys_clk_i) disable iff (srst_i)
      (cmd_valid_i && st_r.phase == ST_IDLE && cmd_i.cmd == CMD_READ_ALARM
       && cmd_i.dnum == DN_VERSION) |=> reply_data_o == FW_VERSION;
  endproperty
  a_version: assert property (p_version) else $error("wrong version"); // [R15]
  property p_mode_read;
    @(posedge sys_clk_i) disable iff (srst_i)
      (cmd_valid_i && st_r.phase == ST_IDLE && cmd_i.cmd == CMD_READ_STAT
       && cmd_i.dnum == DN_TEST_MODE) |=> reply_data_o[2:0] == $past(test_mode_o);
  endproperty
  a_mode_read: assert property (p_mode_read) else $error("wrong mode reply"); // [R17]
  property p_normal_nostop;
    @(posedge sys_clk_i) disable iff (srst_i)
      test_mode_o == TMODE_NORMAL |=> !motor_stop_o;
  endproperty
  a_normal_nostop: assert property (p_normal_nostop) else $error("stop outside test"); // [R16]
endmodule

// ---- tb/master_model.sv ----
`timescale 1ns/10ps
// ****************************************
// Master station on the command link
// ****************************************
module master_model
  import diag_pkg::*;
(
  input wire logic sys_clk_i,
  output logic cmd_valid_o,
  output cmd_t cmd_o,
  output logic link_activity_o
);
  // Idle link at time zero
  initial begin
    cmd_valid_o = 1'b0;
    cmd_o = '0;
    link_activity_o = 1'b0;
  end

  // One command word, one cycle, then the word is scrambled
  task automatic send_cmd(input logic [7:0] c, input logic [7:0] d, input logic [31:0] v);
    @(negedge sys_clk_i);
    cmd_valid_o = 1'b1;
    cmd_o = '{cmd: c, dnum: d, data: v};
    link_activity_o = 1'b1;
    @(negedge sys_clk_i);
    cmd_valid_o = 1'b0;
    cmd_o = ~cmd_o;
    link_activity_o = 1'b0;
  endtask

  // Outputs disabled first, then forced sub-mode selected
  task automatic enter_forced();
    send_cmd(8'h90, 8'h03, KEYWORD);
    send_cmd(CMD_TEST, DN_ZERO, TEST_SEL_DO);
  endtask
endmodule

// ---- tb/tb_servo_diag_command_handler.sv ----
`timescale 1ns/10ps
`define CHECK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module tb_servo_diag_command_handler;
  import diag_pkg::*;
  localparam logic [31:0] FW_SIM = 32'h0000_0123; // Arbitrary value
  logic sys_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic cmd_valid_i;
  cmd_t cmd_i;
  logic link_activity_i;
  logic alarm_event_i = 1'b0;
  logic [15:0] alarm_code_i = '0;
  logic [15:0] op_hours_i = '0;
  logic [SNAP_ITEMS*32-1:0] status_live_i = '0;
  logic [31:0] pos_pulse_i = 32'h0001_86a0;
  logic [31:0] pos_cmd_i = 32'h0000_2710;
  logic [DO_PINS-1:0] normal_do_i = 9'h1a3;
  logic alarm_clear_input_i = 1'b0;
  logic reply_valid_o;
  logic [31:0] reply_data_o;
  logic [DO_PINS-1:0] do_pins_o;
  logic [15:0] active_alarm_o;
  logic [2:0] test_mode_o;
  logic motor_stop_o;
  logic alarm_reset_o;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;
  logic got;
  logic rst_seen;
  logic [31:0] rdata;

  always #2.5 sys_clk_i = ~sys_clk_i;

  master_model master_model_inst (.sys_clk_i(sys_clk_i), .cmd_valid_o(cmd_valid_i),
    .cmd_o(cmd_i), .link_activity_o(link_activity_i));

  servo_diag_command_handler #(.IDLE_COUNT(20), .FW_VERSION(FW_SIM))
    servo_diag_command_handler_inst (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
    .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .link_activity_i(link_activity_i),
    .alarm_event_i(alarm_event_i), .alarm_code_i(alarm_code_i), .op_hours_i(op_hours_i),
    .status_live_i(status_live_i), .pos_pulse_i(pos_pulse_i), .pos_cmd_i(pos_cmd_i),
    .normal_do_i(normal_do_i), .alarm_clear_input_i(alarm_clear_input_i),
    .reply_valid_o(reply_valid_o), .reply_data_o(reply_data_o), .do_pins_o(do_pins_o),
    .active_alarm_o(active_alarm_o), .test_mode_o(test_mode_o),
    .motor_stop_o(motor_stop_o), .alarm_reset_o(alarm_reset_o));

  // Verdict and end of run
  task automatic finish_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      finish_test();
    end
  end

  // Command, then bounded wait for reply and reset pulse
  task automatic xfer(input logic [7:0] c, input logic [7:0] d, input logic [31:0] v);
    got = 1'b0;
    rst_seen = 1'b0;
    master_model_inst.send_cmd(c, d, v);
    for (int i = 0; i < 5; i++) begin
      if (alarm_reset_o === 1'b1) rst_seen = 1'b1;
      if (reply_valid_o === 1'b1 && !got) begin
        got = 1'b1;
        rdata = reply_data_o;
      end
      @(posedge sys_clk_i);
      #1;
    end
  endtask

  // Read and compare one reply
  task automatic rd(input logic [7:0] c, input logic [7:0] d, input logic [31:0] exp);
    xfer(c, d, '0);
    `CHECK(got, 1'b1)
    `CHECK(rdata, exp)
  endtask

  // Alarm occurrence with live status
  task automatic alarm(input logic [15:0] code, input logic [15:0] hrs);
    @(negedge sys_clk_i);
    alarm_event_i = 1'b1;
    alarm_code_i = code;
    op_hours_i = hrs;
    @(negedge sys_clk_i);
    alarm_event_i = 1'b0;
  endtask

  initial begin
    repeat (5) @(negedge sys_clk_i);
    srst_i = 1'b0;
    `CHECK(active_alarm_o, NO_ALARM)
    `CHECK(do_pins_o, normal_do_i)
    rd(CMD_READ_ALARM, DN_ZERO, 32'h0000_00ff);
    rd(CMD_HIST, 8'h1f, 32'h0000_00ff);
    // Three alarms, newest at entry 0
    for (int k = 0; k < SNAP_ITEMS; k++) status_live_i[k*32+:32] = 32'h5a00_0000 + k;
    for (int i = 0; i < 3; i++) alarm(16'(16'h0032 + i), 16'(16'h01f5 + i));
    status_live_i = ~status_live_i;
    rd(CMD_READ_ALARM, DN_ZERO, 32'h0000_0034);
    for (int j = 0; j < 16; j++) begin
      rd(CMD_HIST, 8'(8'h10 + j), (j < 3) ? 32'h34 - j : 32'h0000_00ff);
      rd(CMD_HIST, 8'(8'h20 + j), (j < 3) ? 32'h1f7 - j : 32'h0);
    end
    // Captured status at both range ends
    rd(CMD_SNAP, DN_SNAP_A_LO, 32'h5a00_0000);
    rd(CMD_SNAP, DN_SNAP_A_HI, 32'h5a00_000e);
    rd(CMD_SNAP, DN_SNAP_B_LO, 32'h5a00_000f);
    rd(CMD_SNAP, DN_SNAP_B_HI, 32'h5a00_0018);
    xfer(CMD_HIST, 8'h30, '0);
    `CHECK(got, 1'b0)
    // Wrong keywords leave alarms alone
    xfer(CMD_ALARM_CTL, DN_ZERO, 32'h0000_1ea4);
    `CHECK(rst_seen, 1'b0)
    xfer(CMD_ALARM_CTL, DN_HIST_CLR, 32'h0001_1ea5);
    `CHECK(active_alarm_o, 16'h0034)
    rd(CMD_HIST, 8'h12, 32'h0000_0032);
    xfer(CMD_ALARM_CTL, DN_ZERO, KEYWORD);
    `CHECK(rst_seen, 1'b1)
    rd(CMD_READ_ALARM, DN_ZERO, 32'h0000_00ff);
    // Reset input clears a new alarm
    alarm(16'h0045, 16'h0200);
    `CHECK(active_alarm_o, 16'h0045)
    alarm_clear_input_i = 1'b1;
    @(negedge sys_clk_i);
    alarm_clear_input_i = 1'b0;
    @(negedge sys_clk_i);
    `CHECK(active_alarm_o, NO_ALARM)
    xfer(CMD_ALARM_CTL, DN_HIST_CLR, KEYWORD);
    rd(CMD_HIST, 8'h10, 32'h0000_00ff);
    rd(CMD_HIST, 8'h20, 32'h0);
    rd(CMD_READ_ALARM, DN_POS_PULSE, 32'h0001_86a0);
    rd(CMD_READ_ALARM, DN_POS_CMD, 32'h0000_2710);
    rd(CMD_READ_ALARM, DN_VERSION, FW_SIM);
    // Forced output drive
    rd(CMD_READ_STAT, DN_TEST_MODE, 32'h0);
    xfer(CMD_OUT_SET, DN_OUT_PAT, 32'h0000_01ff);
    `CHECK(do_pins_o, normal_do_i)
    master_model_inst.enter_forced();
    `CHECK(test_mode_o, TMODE_DO)
    rd(CMD_READ_STAT, DN_TEST_MODE, 32'h4);
    xfer(CMD_OUT_SET, DN_OUT_PAT, 32'hffff_fe5a);
    @(negedge sys_clk_i);
    normal_do_i = 9'h0f0;
    #1;
    `CHECK(do_pins_o, 9'h05a)
    repeat (10) @(negedge sys_clk_i);
    `CHECK(motor_stop_o, 1'b0)
    repeat (15) @(negedge sys_clk_i);
    `CHECK(motor_stop_o, 1'b1)
    xfer(CMD_TEST, DN_ZERO, TEST_CANCEL);
    `CHECK(test_mode_o, TMODE_NORMAL)
    `CHECK(do_pins_o, normal_do_i)
    `CHECK(motor_stop_o, 1'b0)
    // Reset in mid run drops forced mode
    master_model_inst.enter_forced();
    @(negedge sys_clk_i);
    srst_i = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    srst_i = 1'b0;
    `CHECK(test_mode_o, TMODE_NORMAL)
    `CHECK(do_pins_o, normal_do_i)
    rd(CMD_READ_STAT, DN_TEST_MODE, 32'h0);
    finish_test();
  end
endmodule
